// ===== shared/cps_pkg.sv
/*
  Shared constants and carriers for the chip power state controller: the power
  control register layout, power state codes, timing counts and the packed
  structs that carry register requests, host activity and clock controls.
  Assumes a 32-bit register word and a 20 MHz core clock.
*/
package cps_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int unsigned CPS_ADDR_W        = 12;
  localparam logic [11:0] CPS_PWR_CTRL_OFFS = 12'h084;

  localparam int unsigned CPS_MODE_LSB  = 29;
  localparam int unsigned CPS_SLEEP_BIT = 28;
  localparam int unsigned CPS_WAKE_BIT  = 27;
  localparam int unsigned CPS_IND_BIT   = 26;
  localparam int unsigned CPS_TU_BIT    = 25;
  localparam int unsigned CPS_SU_BIT    = 22;
  localparam int unsigned CPS_READY_BIT = 0;
  localparam int unsigned CPS_MODE_LANE = 3;
  localparam int unsigned CPS_SU_LANE   = 2;

  // ---------------------------------------------------------------------------
  // Power state codes and reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0] CPS_STATE_ACTIVE      = 3'h0;
  localparam logic [2:0] CPS_STATE_LIGHT_SLEEP = 3'h1;
  localparam logic [2:0] CPS_STATE_PLL_OFF     = 3'h2;
  localparam logic [2:0] CPS_STATE_DEEP_SLEEP  = 3'h3;
  localparam logic [2:0] CPS_MODE_RST          = 3'h0;
  localparam logic       CPS_BIT_RST           = 1'b0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CPS_CLK_PERIOD_NS   = 50;
  localparam int unsigned CPS_WAKE_BOUND_US   = 2000;
  localparam int unsigned CPS_WAKE_BOUND_CYC  = CPS_WAKE_BOUND_US * 1000 / CPS_CLK_PERIOD_NS;
  localparam int unsigned CPS_PLL_SETTLE_CYC  = 16;
  localparam int unsigned CPS_IND_N_DFLT      = 4;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CPS_ST_ACTIVE,
    CPS_ST_SLEEP,
    CPS_ST_WAKE
  } cps_state_e;

  typedef struct packed {
    logic                  req;
    logic                  wr;
    logic [CPS_ADDR_W-1:0] addr;
    logic [3:0]            be;
    logic [31:0]           wdata;
  } cps_reg_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } cps_reg_rsp_s;

  typedef struct packed {
    logic hbi_cs;
    logic hbi_wr;
    logic hbi_rnw;
    logic strobe_enable;
    logic serial_select_n;
    logic serial_clk;
    logic read_done;
  } cps_host_act_s;

  typedef struct packed {
    logic sys_clk_en;
    logic pll_off_req;
    logic xtal_off;
    logic time_unit_clk_en;
    logic stamp_unit_clk_en;
  } cps_clk_ctl_s;

endpackage

// ===== hw/cps_dbl_write.sv
/*
  A control bit guarded against stray writes: it sets only on the second of
  two consecutive writes of one, and any write of zero clears it and the count.
  Assumes wr is a one-cycle pulse per accepted register write to this lane.
*/
`timescale 1ns/10ps
module cps_dbl_write
  import cps_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic wr,
  input  wire logic wbit,
  output logic      bit_q
);

  logic armed_q;
  logic armed_d;
  logic bit_d;

  always_comb begin
    armed_d = armed_q;
    bit_d   = bit_q;
    if (wr) begin
      if (wbit) begin
        bit_d   = armed_q | bit_q;
        armed_d = 1'b1;
      end else begin
        bit_d   = 1'b0;
        armed_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= CPS_BIT_RST;
      bit_q   <= CPS_BIT_RST;
    end else begin
      armed_q <= armed_d;
      bit_q   <= bit_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_set_needs_two: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(bit_q) |-> $past(wr && wbit) && $past(armed_q))
    else $error("guarded bit set without two writes of one");

  a_zero_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && !wbit) |=> !bit_q && !armed_q)
    else $error("write of zero did not clear guarded bit");

endmodule

// ===== hw/cps_power_ctrl.sv
/*
  Chip power state controller: the power control register, the sleep and wake
  sequence, clock and PLL requests, host interface gating and indicator gating.
  Assumes the host interface logic decodes accesses into the register request
  port and reports raw host pin activity, all synchronous to core_clk.
*/
// Behaviour
// - State field write dropped when sleep set
// - Sleep set dropped when state field changes
// - State codes: active, light, PLL-off, deep
// - Sleep request enters state; reads one
// - Ready forced low in low power
// - Host interfaces off while sleeping
// - Auto wake on events when enabled
// - Parallel bus write starts manual wake
// - Writes ignored until awake and read
// - Serial cycle wakes; serial ignored meanwhile
// - Ready rises after PLL re-stabilizes
// - Wake completion clears state and sleep
// - Wake completes within two milliseconds
// - Power register readable in any state
// - Clock-off bits need two writes
// - Clock-off bits gate time, stamp units
// - Indicator off: undriven or inactive level
// - Low power stops system clocks; PLL-off and deep also the PLL, deep the crystal
// - Deep sleep exits only manually
`timescale 1ns/10ps
module cps_power_ctrl
  import cps_pkg::*;
#(
  parameter int unsigned IND_N          = CPS_IND_N_DFLT,
  parameter int unsigned WAKE_BOUND_CYC = CPS_WAKE_BOUND_CYC,
  parameter int unsigned PLL_SETTLE_CYC = CPS_PLL_SETTLE_CYC
)(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire cps_reg_req_s     reg_req,
  output cps_reg_rsp_s          reg_rsp,
  input  wire cps_host_act_s    host_act,
  input  wire logic             wake_event,
  input  wire logic             pll_lock,
  output cps_clk_ctl_s          clk_ctl,
  output logic                  device_ready,
  output logic                  hbi_write_allow,
  output logic                  serial_allow,
  input  wire logic [IND_N-1:0] ind_level,
  input  wire logic [IND_N-1:0] ind_drive_en,
  input  wire logic [IND_N-1:0] ind_push_pull,
  input  wire logic [IND_N-1:0] ind_inactive,
  output logic      [IND_N-1:0] ind_out,
  output logic      [IND_N-1:0] ind_oe
);

  localparam int unsigned BW = $clog2(WAKE_BOUND_CYC + 1);
  localparam int unsigned SW = $clog2(PLL_SETTLE_CYC + 1);

  // ---------------------------------------------------------------------------
  // Host access decode
  // ---------------------------------------------------------------------------
  cps_state_e     st_q;
  cps_state_e     st_d;
  logic [2:0]     mode_q;
  logic [2:0]     mode_d;
  logic           sleep_q;
  logic           sleep_d;
  logic           auto_q;
  logic           auto_d;
  logic           ind_off_q;
  logic           ind_off_d;
  logic           hbi_lock_q;
  logic           hbi_lock_d;
  logic [BW-1:0]  bound_cnt_q;
  logic [BW-1:0]  bound_cnt_d;
  logic [SW-1:0]  settle_cnt_q;
  logic [SW-1:0]  settle_cnt_d;
  logic           tu_off_q;
  logic           su_off_q;
  logic           hit;
  logic           wr_ok;
  logic           mode_lane;
  logic           sleep_wr1;
  logic           mode_new;
  logic           hbi_wr_seen;
  logic           serial_seen;
  logic           auto_wake;
  logic           wake_done;
  logic [2:0]     wr_mode;
  logic [31:0]    rd_word;
  cps_reg_rsp_s   rsp_d;
  cps_clk_ctl_s   clk_d;
  logic           ready_d;

  assign hit     = reg_req.req && (reg_req.addr == CPS_PWR_CTRL_OFFS);
  // Writes are taken only while awake and, after a parallel-bus wake, once the host read is done.
  assign wr_ok   = hit && reg_req.wr && (st_q == CPS_ST_ACTIVE) && !hbi_lock_q;
  assign wr_mode = reg_req.wdata[CPS_MODE_LSB +: 3];
  assign mode_lane = wr_ok && reg_req.be[CPS_MODE_LANE];
  assign sleep_wr1 = mode_lane && reg_req.wdata[CPS_SLEEP_BIT];
  assign mode_new  = mode_lane && (wr_mode != mode_q);

  // Wake detection looks only at the sleep state, so traffic while active has
  // no side effect.
  assign hbi_wr_seen = host_act.hbi_cs &&
                       (host_act.hbi_wr || (!host_act.hbi_rnw && host_act.strobe_enable));
  assign serial_seen = !host_act.serial_select_n && host_act.serial_clk;
  assign auto_wake   = wake_event && auto_q && (mode_q != CPS_STATE_DEEP_SLEEP);

  // ---------------------------------------------------------------------------
  // Sleep and wake sequence
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d         = st_q;
    bound_cnt_d  = bound_cnt_q;
    settle_cnt_d = settle_cnt_q;
    hbi_lock_d   = hbi_lock_q;
    wake_done    = 1'b0;
    unique case (st_q)
      CPS_ST_ACTIVE: begin
        if (sleep_q) begin
          st_d = CPS_ST_SLEEP;
        end
        if (host_act.read_done) begin
          hbi_lock_d = 1'b0;
        end
      end
      CPS_ST_SLEEP: begin
        bound_cnt_d  = '0;
        settle_cnt_d = '0;
        if (hbi_wr_seen) begin
          hbi_lock_d = 1'b1;
        end
        if (hbi_wr_seen || serial_seen || auto_wake) begin
          st_d = CPS_ST_WAKE;
        end
      end
      CPS_ST_WAKE: begin
        bound_cnt_d = bound_cnt_q + BW'(1);
        if (!pll_lock) begin
          settle_cnt_d = '0;
        end else if (settle_cnt_q != SW'(PLL_SETTLE_CYC)) begin
          settle_cnt_d = settle_cnt_q + SW'(1);
        end
        // The bound forces completion so a stuck lock cannot hang the chip;
        // the cost is a possibly unsettled PLL on that rare path.
        if ((pll_lock && settle_cnt_q == SW'(PLL_SETTLE_CYC)) ||
            bound_cnt_q == BW'(WAKE_BOUND_CYC - 1)) begin
          st_d      = CPS_ST_ACTIVE;
          wake_done = 1'b1;
        end
      end
      default: begin
        st_d = CPS_ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= CPS_ST_ACTIVE;
      bound_cnt_q  <= '0;
      settle_cnt_q <= '0;
      hbi_lock_q   <= CPS_BIT_RST;
    end else begin
      st_q         <= st_d;
      bound_cnt_q  <= bound_cnt_d;
      settle_cnt_q <= settle_cnt_d;
      hbi_lock_q   <= hbi_lock_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Power control register fields
  // ---------------------------------------------------------------------------
  always_comb begin
    mode_d    = mode_q;
    sleep_d   = sleep_q;
    auto_d    = auto_q;
    ind_off_d = ind_off_q;
    if (mode_lane) begin
      auto_d    = reg_req.wdata[CPS_WAKE_BIT];
      ind_off_d = reg_req.wdata[CPS_IND_BIT];
      if (!sleep_wr1) begin
        mode_d = wr_mode;
      end
      if (sleep_wr1 && !mode_new) begin
        sleep_d = 1'b1;
      end
    end
    if (wake_done) begin
      mode_d  = CPS_STATE_ACTIVE;
      sleep_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q    <= CPS_MODE_RST;
      sleep_q   <= CPS_BIT_RST;
      auto_q    <= CPS_BIT_RST;
      ind_off_q <= CPS_BIT_RST;
    end else begin
      mode_q    <= mode_d;
      sleep_q   <= sleep_d;
      auto_q    <= auto_d;
      ind_off_q <= ind_off_d;
    end
  end

  cps_dbl_write u_tu_off (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr       (mode_lane),
    .wbit     (reg_req.wdata[CPS_TU_BIT]),
    .bit_q    (tu_off_q)
  );

  cps_dbl_write u_su_off (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr       (wr_ok && reg_req.be[CPS_SU_LANE]),
    .wbit     (reg_req.wdata[CPS_SU_BIT]),
    .bit_q    (su_off_q)
  );

  // ---------------------------------------------------------------------------
  // Read path, clock requests and status outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_word                   = '0;
    rd_word[CPS_MODE_LSB +: 3] = mode_q;
    rd_word[CPS_SLEEP_BIT]    = sleep_q;
    rd_word[CPS_WAKE_BIT]     = auto_q;
    rd_word[CPS_IND_BIT]      = ind_off_q;
    rd_word[CPS_TU_BIT]       = tu_off_q;
    rd_word[CPS_SU_BIT]       = su_off_q;
    rd_word[CPS_READY_BIT]    = device_ready;
    // Every hit is answered in every state, so a read never hangs.
    rsp_d.ack   = hit;
    rsp_d.rdata = hit ? rd_word : reg_rsp.rdata;
    ready_d     = (st_d == CPS_ST_ACTIVE);
    clk_d.sys_clk_en  = ready_d;
    clk_d.pll_off_req = (st_d == CPS_ST_SLEEP) &&
                        (mode_q == CPS_STATE_PLL_OFF || mode_q == CPS_STATE_DEEP_SLEEP);
    clk_d.xtal_off    = (st_d == CPS_ST_SLEEP) && (mode_q == CPS_STATE_DEEP_SLEEP);
    clk_d.time_unit_clk_en  = ready_d && !tu_off_q;
    clk_d.stamp_unit_clk_en = ready_d && !tu_off_q && !su_off_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rsp         <= '0;
      device_ready    <= 1'b1;
      clk_ctl         <= '{sys_clk_en: 1'b1, pll_off_req: 1'b0, xtal_off: 1'b0,
                           time_unit_clk_en: 1'b1, stamp_unit_clk_en: 1'b1};
      hbi_write_allow <= 1'b1;
      serial_allow    <= 1'b1;
    end else begin
      reg_rsp         <= rsp_d;
      device_ready    <= ready_d;
      clk_ctl         <= clk_d;
      hbi_write_allow <= ready_d && !hbi_lock_d;
      serial_allow    <= ready_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Indicator gating
  // ---------------------------------------------------------------------------
  logic [IND_N-1:0] ind_out_d;
  logic [IND_N-1:0] ind_oe_d;

  for (genvar i = 0; i < IND_N; i++) begin : g_ind
    // Push-pull pins hold their inactive level; open pins float.
    assign ind_out_d[i] = ind_off_q ? ind_inactive[i] : ind_level[i];
    assign ind_oe_d[i]  = ind_off_q ? ind_push_pull[i] : ind_drive_en[i];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_out <= '0;
      ind_oe  <= '0;
    end else begin
      ind_out <= ind_out_d;
      ind_oe  <= ind_oe_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_mode_kept_sleep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sleep_wr1 && !wake_done) |=> $stable(mode_q))
    else $error("state field changed by a write that also set sleep");

  a_sleep_new_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode_new && !sleep_q) |=> !sleep_q)
    else $error("sleep request taken with new state field");

  a_sleep_enters: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sleep_wr1 && !mode_new) |=> ##1 (st_q == CPS_ST_SLEEP))
    else $error("sleep request did not enter sleep");

  a_ready_low_sleep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q != CPS_ST_ACTIVE) |-> !device_ready && !clk_ctl.sys_clk_en && !serial_allow)
    else $error("ready or clocks on outside active state");

  a_auto_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == CPS_ST_SLEEP && auto_wake) |=> (st_q == CPS_ST_WAKE))
    else $error("enabled wake event did not start wake");

  a_deep_manual: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == CPS_ST_SLEEP && (!auto_q || mode_q == CPS_STATE_DEEP_SLEEP) &&
     !hbi_wr_seen && !serial_seen) |=> (st_q == CPS_ST_SLEEP))
    else $error("left sleep without a permitted wake");

  a_manual_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == CPS_ST_SLEEP && (hbi_wr_seen || serial_seen)) |=> (st_q == CPS_ST_WAKE))
    else $error("host activity did not start wake");

  a_wake_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == CPS_ST_WAKE && st_d == CPS_ST_ACTIVE) |=>
      (mode_q == CPS_STATE_ACTIVE) && !sleep_q && device_ready)
    else $error("wake completion left fields set");

  a_wake_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == CPS_ST_WAKE) |-> (bound_cnt_q < BW'(WAKE_BOUND_CYC)))
    else $error("wake ran past its bound");

  a_write_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == CPS_ST_SLEEP && hbi_wr_seen) |=> ##1 !hbi_write_allow)
    else $error("writes allowed right after parallel wake");

  c_sleep_cycle: cover property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == CPS_ST_WAKE) ##1 (st_q == CPS_ST_ACTIVE));
  c_deep_entry: cover property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == CPS_ST_SLEEP) && clk_ctl.xtal_off);
  c_tu_off: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(tu_off_q));

endmodule

// ===== bench/cps_pll_model.sv
/*
  Behavioural PLL and crystal facing the controller's clock requests.
  Assumes the bench clock and reset; relock time is a parameter.
*/
`timescale 1ns/10ps
module cps_pll_model
  import cps_pkg::*;
#(
  parameter int unsigned LOCK_CYC = 10
)(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire cps_clk_ctl_s clk_ctl,
  output logic              pll_lock
);
  logic [7:0] cnt_q;

  // Lock is lost at once when stopped, so a ready that ignores lock shows up.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'(LOCK_CYC);
    end else if (clk_ctl.pll_off_req || clk_ctl.xtal_off) begin
      cnt_q <= 8'h00;
    end else if (cnt_q < 8'(LOCK_CYC)) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign pll_lock = (cnt_q >= 8'(LOCK_CYC));
endmodule

// ===== bench/cps_power_ctrl_test.sv
/*
  Self-checking bench for the power state controller: register accesses,
  sleep and wake, clock-off bits and indicator gating.
  Assumes cps_pkg, the PLL model and shortened wake and settle counts.
*/
`timescale 1ns/10ps
module cps_power_ctrl_test;
  import cps_pkg::*;
  localparam int unsigned WB = 64;
  localparam cps_host_act_s IDLE = 7'b0010100;
  localparam cps_host_act_s PWR  = 7'b1110100;
  localparam cps_host_act_s PSTB = 7'b1001100;
  localparam cps_host_act_s SER  = 7'b0010010;
  localparam cps_host_act_s RDN  = 7'b0010101;
  logic          core_clk, rst_n, wake_event, pll_lock;
  logic          device_ready, hbi_write_allow, serial_allow;
  cps_reg_req_s  req;
  cps_reg_rsp_s  rsp;
  cps_host_act_s act;
  cps_clk_ctl_s  cc;
  logic [3:0]    lvl, den, pp, ina, iout, ioe;
  int            bad_count, n_compared;

  cps_power_ctrl #(.IND_N(4), .WAKE_BOUND_CYC(WB), .PLL_SETTLE_CYC(4)) i_cps_power_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .reg_req(req), .reg_rsp(rsp), .host_act(act),
    .wake_event(wake_event), .pll_lock(pll_lock), .clk_ctl(cc), .device_ready(device_ready),
    .hbi_write_allow(hbi_write_allow), .serial_allow(serial_allow), .ind_level(lvl),
    .ind_drive_en(den), .ind_push_pull(pp), .ind_inactive(ina), .ind_out(iout),
    .ind_oe(ioe));
  cps_pll_model i_cps_pll_model (.core_clk(core_clk), .rst_n(rst_n), .clk_ctl(cc),
    .pll_lock(pll_lock));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Fields arrive as plain integers so calls need no sized literals; each is cut on purpose.
  function automatic logic [31:0] w(input int m, s, a, i, t, u, r);
    return {m[2:0], s[0], a[0], i[0], t[0], 2'b00, u[0], 21'h0, r[0]};
  endfunction

  task automatic acc(input logic wr, input logic [3:0] be, input logic [31:0] d,
                     input logic [11:0] a);
    @(negedge core_clk);
    req = '{1'b1, wr, a, be, d};
    @(negedge core_clk);
    req.req = 1'b0;
  endtask

  task automatic wr(input logic [3:0] be, input logic [31:0] d);
    acc(1'b1, be, d, CPS_PWR_CTRL_OFFS);
    chk({31'h0, rsp.ack}, 32'h1);
  endtask

  task automatic rd(input logic [31:0] exp);
    acc(1'b0, 4'h1, 32'h0, CPS_PWR_CTRL_OFFS);
    chk({31'h0, rsp.ack}, 32'h1);
    chk(rsp.rdata, exp);
  endtask

  task automatic pulse(input cps_host_act_s v);
    @(negedge core_clk);
    act = v;
    @(negedge core_clk);
    act = IDLE;
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (device_ready !== 1'b1 && n < WB + 8) begin
      @(negedge core_clk);
      n++;
    end
    chk(32'(n <= WB), 32'h1);
    chk({31'h0, pll_lock}, 32'h1);
  endtask

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    #1000000;
    bad_count++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    act = IDLE;
    wake_event = 1'b0;
    lvl = 4'h5;
    den = 4'h3;
    pp = 4'h9;
    ina = 4'h6;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    rd(w(0, 0, 0, 0, 0, 0, 1));
    acc(1'b0, 4'hf, 32'h0, 12'h088);
    chk({31'h0, rsp.ack}, 32'h0);
    chk({24'h0, iout, ioe}, 32'h53);
    wr(4'h8, w(0, 0, 0, 1, 0, 0, 0));
    @(negedge core_clk);
    chk({24'h0, iout, ioe}, 32'h69);
    // Two writes of one must set the bit; a read between them does not break the pair.
    wr(4'h8, w(0, 0, 0, 0, 1, 0, 0));
    rd(w(0, 0, 0, 0, 0, 0, 1));
    wr(4'h8, w(0, 0, 0, 0, 1, 0, 0));
    rd(w(0, 0, 0, 0, 1, 0, 1));
    chk({30'h0, cc.time_unit_clk_en, cc.stamp_unit_clk_en}, 32'h0);
    wr(4'h4, w(0, 0, 0, 0, 0, 1, 0));
    wr(4'h4, w(0, 0, 0, 0, 0, 0, 0));
    wr(4'h4, w(0, 0, 0, 0, 0, 1, 0));
    rd(w(0, 0, 0, 0, 1, 0, 1));
    wr(4'h4, w(0, 0, 0, 0, 0, 1, 0));
    rd(w(0, 0, 0, 0, 1, 1, 1));
    chk({30'h0, cc.time_unit_clk_en, cc.stamp_unit_clk_en}, 32'h0);
    wr(4'hc, 32'h0);
    rd(w(0, 0, 0, 0, 0, 0, 1));
    // The stamp gate alone must leave the rest of the time unit clocked.
    wr(4'h4, w(0, 0, 0, 0, 0, 1, 0));
    wr(4'h4, w(0, 0, 0, 0, 0, 1, 0));
    @(negedge core_clk);
    chk({30'h0, cc.time_unit_clk_en, cc.stamp_unit_clk_en}, 32'h2);
    wr(4'h4, 32'h0);
    // Light sleep, left by a wake event.
    wr(4'h8, w(1, 0, 1, 0, 0, 0, 0));
    rd(w(1, 0, 1, 0, 0, 0, 1));
    wr(4'h8, w(2, 1, 1, 0, 0, 0, 0));
    rd(w(1, 0, 1, 0, 0, 0, 1));
    wr(4'h8, w(1, 1, 1, 0, 0, 0, 0));
    @(negedge core_clk);
    chk({31'h0, device_ready}, 32'h0);
    rd(w(1, 1, 1, 0, 0, 0, 0));
    chk({27'h0, serial_allow, hbi_write_allow, cc.sys_clk_en, cc.pll_off_req, cc.xtal_off},
        32'h0);
    wr(4'h8, w(1, 1, 1, 1, 0, 0, 0));
    rd(w(1, 1, 1, 0, 0, 0, 0));
    wake_event = 1'b1;
    @(negedge core_clk);
    wake_event = 1'b0;
    wait_ready();
    rd(w(0, 0, 1, 0, 0, 0, 1));
    // Deep sleep ignores wake events; a serial cycle wakes it.
    wr(4'h8, w(3, 0, 1, 0, 0, 0, 0));
    wr(4'h8, w(3, 1, 1, 0, 0, 0, 0));
    @(negedge core_clk);
    chk({30'h0, cc.pll_off_req, cc.xtal_off}, 32'h3);
    wake_event = 1'b1;
    repeat (WB + 8) @(negedge core_clk);
    wake_event = 1'b0;
    chk({31'h0, device_ready}, 32'h0);
    pulse(SER);
    wait_ready();
    chk({31'h0, serial_allow}, 32'h1);
    rd(w(0, 0, 1, 0, 0, 0, 1));
    // PLL-off sleep, manual wake only, then a parallel write wakes it.
    wr(4'h8, w(2, 0, 0, 0, 0, 0, 0));
    wr(4'h8, w(2, 1, 0, 0, 0, 0, 0));
    @(negedge core_clk);
    chk({30'h0, cc.pll_off_req, cc.xtal_off}, 32'h2);
    pulse(RDN);
    wake_event = 1'b1;
    repeat (8) @(negedge core_clk);
    wake_event = 1'b0;
    chk({31'h0, device_ready}, 32'h0);
    pulse(PWR);
    wait_ready();
    chk({31'h0, hbi_write_allow}, 32'h0);
    wr(4'h8, w(0, 0, 0, 1, 0, 0, 0));
    rd(w(0, 0, 0, 0, 0, 0, 1));
    pulse(RDN);
    @(negedge core_clk);
    chk({31'h0, hbi_write_allow}, 32'h1);
    wr(4'h8, w(0, 0, 0, 1, 0, 0, 0));
    rd(w(0, 0, 0, 1, 0, 0, 1));
    // Host activity while active must not start a wake.
    pulse(PSTB);
    pulse(SER);
    repeat (3) @(negedge core_clk);
    chk({29'h0, device_ready, hbi_write_allow, serial_allow}, 32'h7);
    rd(w(0, 0, 0, 1, 0, 0, 1));
    // A chip reset taken in mid-sleep must clear every field and bring ready back to one.
    wr(4'h8, w(1, 0, 1, 0, 0, 0, 0));
    wr(4'h8, w(1, 1, 1, 0, 0, 0, 0));
    @(negedge core_clk);
    chk({31'h0, device_ready}, 32'h0);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    chk({31'h0, device_ready}, 32'h1);
    rd(w(0, 0, 0, 0, 0, 0, 1));
    wrap_up();
  end
endmodule
